/* File: rtl/d3b_pkg.sv */
package d3b_pkg;

  // Command bus decode, one command per clock
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_PRE,
    CMD_RD,
    CMD_WR
  } d3b_cmd_type;

  // Burst-length field codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_BC4 = 2'h2;

  // Address bit positions on column commands
  localparam int A12_POS = 12;
  localparam int AP_POS = 10;
  localparam int COL_BITS = 10;

  // Data moves as rise/fall beat pairs, one pair per clock
  localparam logic [1:0] LAST_PAIR_BL8 = 2'h3;
  localparam logic [1:0] LAST_PAIR_BC4 = 2'h1;

  // Depth of the command-age pipeline, bounds AL+CL and AL+CWL
  localparam int LAT_DEPTH = 32;
  localparam logic [5:0] RD_TAP_OFS = 6'h02;
  localparam logic [5:0] WR_TAP_OFS = 6'h01;

endpackage

/* File: rtl/d3b_pair_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module d3b_pair_ram #(
  parameter int AW = 12,
  parameter int DW = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic re,
  input wire logic [DW/8-1:0] be,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem_q;
  logic [DW-1:0] next_rdata;

  // One array per byte lane, so no two processes write one memory
  genvar g;
  generate
    for (g = 0; g < DW/8; g++) begin : g_lane
      logic [7:0] lane [2**AW];
      always_ff @(posedge clk) begin
        if (we && be[g]) begin
          lane[addr] <= wdata[8*g +: 8];
        end
      end
      assign mem_q[8*g +: 8] = lane[addr];
    end
  endgenerate

  // Read data held until the next read
  always_comb begin
    next_rdata = re ? mem_q : rdata;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/d3b_burst_engine.sv */
// Behaviour
// - With on-the-fly field, A12 low gives 4-beat chop, high gives 8 beats.
// - A12 selects burst length only, never part of the column address.
// - On-the-fly length works with and without auto-precharge.
// - Field 10 makes every read and write a fixed 4-beat chop.
// - One mask bit per eight data lines blocks storing that byte.
// - Mask lines sampled with the same timing as their data.
// - Mask inputs are ignored during read bursts.
// - Data setup/hold fault corrupts only the addressed write location.
// - Strobe timing fault confines damage to that write; device keeps working.
// - Read data starts AL plus CL clocks after the read command.
`timescale 1ns/1ps
`default_nettype none
module d3b_burst_engine
  import d3b_pkg::*;
#(
  parameter int DQ_W = 16,
  parameter int BANK_BITS = 3,
  parameter int ROW_BITS = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire d3b_cmd_type cmd,
  input wire logic [BANK_BITS-1:0] ba,
  input wire logic [13:0] addr,
  input wire logic [1:0] mode_bl,
  input wire logic [4:0] mode_cl,
  input wire logic [4:0] mode_al,
  input wire logic [4:0] mode_cwl,
  input wire logic [DQ_W-1:0] dq_in_rise,
  input wire logic [DQ_W-1:0] dq_in_fall,
  input wire logic [DQ_W/8-1:0] dm_rise,
  input wire logic [DQ_W/8-1:0] dm_fall,
  input wire logic strobe_fault,
  output logic [DQ_W-1:0] dq_out_rise,
  output logic [DQ_W-1:0] dq_out_fall,
  output logic dq_oe,
  output logic [2**BANK_BITS-1:0] bank_open
);
  localparam int NBANK = 2**BANK_BITS;
  localparam int BW = BANK_BITS + ROW_BITS + COL_BITS - 3;
  localparam int AW = BW + 2;
  localparam int EW = BW + 3;

  // Pair address inside a burst; nibble order follows column bit 2
  function automatic logic [AW-1:0] pair_addr(input logic [BW-1:0] base,
                                              input logic nib,
                                              input logic [1:0] j);
    pair_addr = {base, nib ^ j[1], j[0]};
  endfunction

  logic [ROW_BITS-1:0] row_of [NBANK];
  logic [ROW_BITS-1:0] next_row_of [NBANK];
  logic [NBANK-1:0] next_bank_open;
  logic pv [LAT_DEPTH];
  logic [EW-1:0] pe [LAT_DEPTH];
  logic next_pv0;
  logic [EW-1:0] next_pe0;
  logic col_cmd;
  logic cmd_bc4;
  logic [4:0] rd_idx;
  logic [4:0] wr_idx;
  logic launch_rd;
  logic launch_wr;
  logic eng_busy, next_eng_busy;
  logic eng_wr, next_eng_wr;
  logic eng_bc4, next_eng_bc4;
  logic eng_nib, next_eng_nib;
  logic [BW-1:0] eng_base, next_eng_base;
  logic [1:0] eng_j, next_eng_j;
  logic next_dq_oe;
  logic cur_act, cur_wr, cur_bc4, cur_nib;
  logic [BW-1:0] cur_base;
  logic [1:0] cur_j;
  logic mem_we, mem_re;
  logic [DQ_W/4-1:0] mem_be;
  logic [AW-1:0] mem_addr;

  // Bank row tracking; auto-precharge closes right after the column command
  always_comb begin
    next_bank_open = bank_open;
    for (int b = 0; b < NBANK; b++) begin
      next_row_of[b] = row_of[b];
    end
    case (cmd)
      CMD_ACT: begin
        next_bank_open[ba] = 1'b1;
        next_row_of[ba] = addr[ROW_BITS-1:0];
      end
      CMD_PRE: begin
        if (addr[AP_POS]) begin
          next_bank_open = '0;
        end else begin
          next_bank_open[ba] = 1'b0;
        end
      end
      CMD_RD, CMD_WR: begin
        if (addr[AP_POS]) begin
          next_bank_open[ba] = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bank_open <= '0;
      for (int b = 0; b < NBANK; b++) begin
        row_of[b] <= '0;
      end
    end else begin
      bank_open <= next_bank_open;
      for (int b = 0; b < NBANK; b++) begin
        row_of[b] <= next_row_of[b];
      end
    end
  end

  // Burst length per command; fixed chop overrides A12
  always_comb begin
    col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);
    case (mode_bl)
      BL_BC4: cmd_bc4 = 1'b1;
      BL_OTF: cmd_bc4 = !addr[A12_POS];
      default: cmd_bc4 = 1'b0;
    endcase
    next_pv0 = col_cmd;
    // Column taken from A9..A3 and A2 only; A12 never enters it
    next_pe0 = {cmd == CMD_WR, cmd_bc4, addr[2], ba, row_of[ba],
                addr[COL_BITS-1:3]};
  end

  // Command-age pipeline: entry k holds the command issued k+1 clocks ago
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pv[0] <= 1'b0;
      pe[0] <= '0;
    end else begin
      pv[0] <= next_pv0;
      pe[0] <= next_pe0;
    end
  end

  genvar k;
  generate
    for (k = 1; k < LAT_DEPTH; k++) begin : g_age
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pv[k] <= 1'b0;
          pe[k] <= '0;
        end else begin
          pv[k] <= pv[k-1];
          pe[k] <= pe[k-1];
        end
      end
    end
  endgenerate

  // Read launches one clock early to cover the registered RAM read
  always_comb begin
    rd_idx = 5'(6'(mode_al) + 6'(mode_cl) - RD_TAP_OFS);
    wr_idx = 5'(6'(mode_al) + 6'(mode_cwl) - WR_TAP_OFS);
    launch_wr = pv[wr_idx] && pe[wr_idx][EW-1];
    launch_rd = pv[rd_idx] && !pe[rd_idx][EW-1] && !launch_wr;
  end

  // Burst engine: a launch restarts it, spacing of 4 keeps bursts apart
  always_comb begin
    cur_act = launch_rd || launch_wr || eng_busy;
    if (launch_rd || launch_wr) begin
      cur_wr = launch_wr;
      cur_bc4 = launch_wr ? pe[wr_idx][EW-2] : pe[rd_idx][EW-2];
      cur_nib = launch_wr ? pe[wr_idx][EW-3] : pe[rd_idx][EW-3];
      cur_base = launch_wr ? pe[wr_idx][BW-1:0] : pe[rd_idx][BW-1:0];
      cur_j = 2'h0;
    end else begin
      cur_wr = eng_wr;
      cur_bc4 = eng_bc4;
      cur_nib = eng_nib;
      cur_base = eng_base;
      cur_j = eng_j;
    end
    next_eng_busy = cur_act &&
      (cur_j != (cur_bc4 ? LAST_PAIR_BC4 : LAST_PAIR_BL8));
    next_eng_wr = cur_wr;
    next_eng_bc4 = cur_bc4;
    next_eng_nib = cur_nib;
    next_eng_base = cur_base;
    next_eng_j = cur_j + 2'h1;
    mem_addr = pair_addr(cur_base, cur_nib, cur_j);
    // Faulty strobes still land only on this burst's own pair address
    mem_we = cur_act && cur_wr;
    mem_re = cur_act && !cur_wr;
    // Mask sampled in the same clock as its data; ignored for reads
    mem_be = ~{dm_fall, dm_rise};
    next_dq_oe = mem_re;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eng_busy <= 1'b0;
      eng_wr <= 1'b0;
      eng_bc4 <= 1'b0;
      eng_nib <= 1'b0;
      eng_base <= '0;
      eng_j <= 2'h0;
      dq_oe <= 1'b0;
    end else begin
      eng_busy <= next_eng_busy;
      eng_wr <= next_eng_wr;
      eng_bc4 <= next_eng_bc4;
      eng_nib <= next_eng_nib;
      eng_base <= next_eng_base;
      eng_j <= next_eng_j;
      dq_oe <= next_dq_oe;
    end
  end

  d3b_pair_ram #(
    .AW(AW),
    .DW(2*DQ_W)
  ) u_ram (
    .clk(clk),
    .rst(rst),
    .addr(mem_addr),
    .we(mem_we),
    .re(mem_re),
    .be(mem_be),
    .wdata({dq_in_fall, dq_in_rise}),
    .rdata({dq_out_fall, dq_out_rise})
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_fixed_chop: assert property (
    col_cmd && mode_bl == BL_BC4 |=> pv[0] && pe[0][EW-2])
    else $error("fixed chop field did not give a 4-beat burst");
  chk_otf_select: assert property (
    col_cmd && mode_bl == BL_OTF |=> pe[0][EW-2] == !$past(addr[A12_POS]))
    else $error("A12 did not select burst length");
  chk_col_no_a12: assert property (
    col_cmd |=> pe[0][COL_BITS-4:0] == $past(addr[COL_BITS-1:3]))
    else $error("column field corrupted");
  chk_rd_start: assert property (
    launch_rd |=> dq_oe)
    else $error("read data not driven at read latency");
  chk_bl8_span: assert property (
    launch_rd && !pe[rd_idx][EW-2] ##1 (!launch_rd && !launch_wr) [*4]
    |-> dq_oe && $past(dq_oe) && $past(dq_oe, 2) && $past(dq_oe, 3)
    ##1 !dq_oe)
    else $error("8-beat read did not span four clocks");
  chk_bc4_span: assert property (
    launch_rd && pe[rd_idx][EW-2] && !launch_wr ##1 !launch_rd && !launch_wr
    |-> ##1 dq_oe ##1 !dq_oe)
    else $error("chopped read did not span two clocks");
  chk_rd_no_mask: assert property (
    mem_re |-> !mem_we)
    else $error("mask path active during read");
  chk_mask_lanes: assert property (
    mem_we |-> mem_be == ~{dm_fall, dm_rise} && cur_act)
    else $error("mask did not gate byte lanes");
  chk_fault_local: assert property (
    strobe_fault && !(cur_act && cur_wr) |-> !mem_we)
    else $error("strobe fault reached memory outside a write");

  cov_otf_bc4_read: cover property (launch_rd && pe[rd_idx][EW-2]);
  cov_bl8_write: cover property (launch_wr && !pe[wr_idx][EW-2]);
  cov_ap_column: cover property (col_cmd && addr[AP_POS]);
endmodule
`default_nettype wire

/* File: tb/d3b_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module d3b_ctrl_model
  import d3b_pkg::*;
#(
  parameter int WL = 3
) (
  input wire logic clk,
  output var d3b_cmd_type cmd,
  output logic [2:0] ba,
  output logic [13:0] addr,
  output logic [15:0] dq_in_rise,
  output logic [15:0] dq_in_fall,
  output logic [1:0] dm_rise,
  output logic [1:0] dm_fall,
  output logic strobe_fault
);
  // Quiet bus at time zero
  initial begin
    cmd = CMD_NOP;
    ba = 3'h0;
    addr = 14'h0000;
    dq_in_rise = 16'h0000;
    dq_in_fall = 16'h0000;
    dm_rise = 2'h0;
    dm_fall = 2'h0;
    strobe_fault = 1'b0;
  end

  // One command, then its write pairs WL clocks on
  task automatic op(input d3b_cmd_type c, input logic [2:0] b,
    input logic [13:0] a, input logic [127:0] d, input logic [15:0] m,
    input logic f);
    int n;
    n = (c == CMD_WR) ? 4 : 0;
    @(posedge clk);
    cmd <= c;
    ba <= b;
    addr <= a;
    @(posedge clk);
    cmd <= CMD_NOP;
    repeat (WL - 1) @(posedge clk);
    for (int j = 0; j < n; j++) begin
      dq_in_rise <= d[32*j +: 16];
      dq_in_fall <= d[32*j+16 +: 16];
      dm_rise <= m[4*j +: 2];
      dm_fall <= m[4*j+2 +: 2];
      strobe_fault <= f;
      @(posedge clk);
    end
    // Stale beats inverted so they never pass for live data
    dq_in_rise <= ~dq_in_rise;
    dq_in_fall <= ~dq_in_fall;
    dm_rise <= ~dm_rise;
    dm_fall <= ~dm_fall;
    strobe_fault <= 1'b0;
    // Wide gap covers every bank interval after the burst
    repeat (10) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import d3b_pkg::*;
  logic [4:0] mode_al = 5'h01;
  logic [4:0] mode_cl = 5'h03;
  logic [4:0] mode_cwl = 5'h02;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode_bl = BL_OTF;
  d3b_cmd_type cmd;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [15:0] dqr, dqf, qr, qf;
  logic [1:0] dmr, dmf;
  logic sf, oe;
  logic [7:0] bo;
  logic [1:0] rows [8];
  logic [31:0] mem [int];
  logic [63:0] notes [$];
  logic [63:0] nt;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  int rd_cyc = 0;

  always #50 clk = ~clk;

  d3b_ctrl_model #(.WL(3)) ctl (.clk(clk), .cmd(cmd), .ba(ba),
    .addr(addr), .dq_in_rise(dqr), .dq_in_fall(dqf), .dm_rise(dmr),
    .dm_fall(dmf), .strobe_fault(sf));

  d3b_burst_engine dut (.clk(clk), .rst(rst), .cmd(cmd), .ba(ba),
    .addr(addr), .mode_bl(mode_bl), .mode_cl(mode_cl), .mode_al(mode_al),
    .mode_cwl(mode_cwl), .dq_in_rise(dqr), .dq_in_fall(dqf), .dm_rise(dmr),
    .dm_fall(dmf), .strobe_fault(sf), .dq_out_rise(qr),
    .dq_out_fall(qf), .dq_oe(oe), .bank_open(bo));

  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    checks_done++;
    if (a !== e) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic int blen(logic [13:0] a);
    return (mode_bl == BL_BC4 || (mode_bl == BL_OTF && !a[A12_POS])) ? 2 : 4;
  endfunction

  function automatic int key(logic [2:0] b, logic [13:0] a, int j);
    return {b, rows[b], a[9:3], a[2] ^ j[1], j[0]};
  endfunction

  // Reference store updated byte by byte unless masked or faulted
  task automatic wr(input logic [2:0] b, input logic [13:0] a,
    input logic [15:0] m, input logic f);
    logic [127:0] d;
    d = {$urandom, $urandom, $urandom, $urandom};
    for (int j = 0; j < blen(a); j++)
      for (int i = 0; i < 4; i++)
        if (!f && !m[4*j+i]) mem[key(b, a, j)][8*i +: 8] = d[32*j+8*i +: 8];
    ctl.op(CMD_WR, b, a, d, m, f);
  endtask

  task automatic rd(input logic [2:0] b, input logic [13:0] a);
    for (int j = 0; j < blen(a); j++)
      notes.push_back({j, mem[key(b, a, j)]});
    ctl.op(CMD_RD, b, a, 128'h0, 16'h0, 1'b0);
  endtask

  task automatic act(input logic [2:0] b);
    rows[b] = 2'($urandom);
    ctl.op(CMD_ACT, b, {12'h000, rows[b]}, 128'h0, 16'h0, 1'b0);
  endtask

  task automatic setbl(input logic [1:0] v);
    @(posedge clk);
    mode_bl <= v;
    @(posedge clk);
  endtask

  // Cycle count and moment of the last read command
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmd === CMD_RD)
      rd_cyc <= cyc;
    if (cyc > 3000) begin
      n_fail++;
      results();
    end
  end

  // Each read pair checked against the oldest note, value and moment
  always @(negedge clk) begin
    if (oe !== 1'b0) begin
      if (notes.size() == 0) begin
        chk(32'h0, 32'h1);
      end else begin
        nt = notes.pop_front();
        chk(nt[31:0], {qf, qr});
        chk(nt[63:32] + rd_cyc + mode_al + mode_cl, cyc);
      end
    end
  end

  initial begin
    void'($urandom(32'h8540a6de));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({oe, bo}, 32'h0);
    act(3'h1);
    wr(3'h1, 14'h1010, 16'h0, 1'b0);
    rd(3'h1, 14'h1010);
    rd(3'h1, 14'h0010);
    rd(3'h1, 14'h0014);
    wr(3'h1, 14'h0014, 16'h0, 1'b0);
    rd(3'h1, 14'h1010);
    $display("on-the-fly burst test done");
    wr(3'h1, 14'h0010, 16'h0, 1'b0);
    wr(3'h1, 14'h1010, 16'($urandom), 1'b0);
    rd(3'h1, 14'h1010);
    $display("write mask test done");
    setbl(BL_BC4);
    wr(3'h1, 14'h1020, 16'h0, 1'b0);
    rd(3'h1, 14'h1020);
    setbl(BL_FIXED8);
    wr(3'h1, 14'h0030, 16'h0, 1'b0);
    rd(3'h1, 14'h0030);
    $display("fixed burst field test done");
    setbl(BL_OTF);
    wr(3'h1, 14'h1038, 16'h0, 1'b1);
    rd(3'h1, 14'h1010);
    rd(3'h1, 14'h0030);
    $display("strobe fault test done");
    for (int b = 2; b < 6; b++) begin
      act(3'(b));
      chk(bo[b], 32'h1);
      addr_ap(3'(b), (14'($urandom) & 14'h13FF) | 14'h0400);
    end
    $display("auto-precharge test done");
    // Read latency moved; write latency kept at the model's figure
    @(posedge clk);
    mode_al <= 5'h00;
    mode_cl <= 5'h05;
    mode_cwl <= 5'h03;
    wr(3'h1, 14'h1040, 16'h0, 1'b0);
    rd(3'h1, 14'h1040);
    rd(3'h1, 14'h0044);
    $display("latency test done");
    act(3'h6);
    act(3'h7);
    ctl.op(CMD_PRE, 3'h6, 14'h0000, 128'h0, 16'h0, 1'b0);
    chk(bo[7:6], 32'h2);
    // Reset in mid-run closes every bank and quiets the read path
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({oe, bo}, 32'h0);
    act(3'h2);
    act(3'h7);
    ctl.op(CMD_PRE, 3'h0, 14'h0400, 128'h0, 16'h0, 1'b0);
    chk(bo, 32'h0);
    $display("precharge and reset test done");
    repeat (10) @(posedge clk);
    chk(32'(notes.size()), 32'h0);
    results();
  end

  // Write and read back with auto-precharge, bank closes each time
  task automatic addr_ap(input logic [2:0] b, input logic [13:0] a);
    wr(b, a, 16'h0, 1'b0);
    chk(bo[b], 32'h0);
    // Same row again, so the read finds what the write stored
    ctl.op(CMD_ACT, b, {12'h000, rows[b]}, 128'h0, 16'h0, 1'b0);
    rd(b, a);
    chk(bo[b], 32'h0);
  endtask
endmodule
`default_nettype wire
